// ---- hw/dpsk_packet_detector.sv ----
// packet detection, bit timing, word sync and data word decode
`timescale 1ns/10ps
module dpsk_packet_detector #(
   parameter int SAMPLE_W = 16,
   parameter int HUNT_LIMIT = 64
) (
   input wire logic sys_clk_i,                       // system clock, 200 MHz
   input wire logic rst_i,                           // synchronous reset
   input wire logic signed [SAMPLE_W-1:0] sample_i,  // filtered adc sample
   input wire logic sample_valid_i,                  // sample strobe
   input wire logic [7:0] carrier_threshold_i,       // carrier count threshold
   output logic [7:0] byte_o,                        // received data byte
   output logic byte_valid_o,                        // byte strobe
   output logic packet_done_o,                       // packet closed strobe
   output logic error_o,                             // parity, suffix or data-word-after-end-word error strobe
   output logic receiving_o                          // packet in progress
);
   localparam int ACC_W = 2 * SAMPLE_W + 5;

   corr_if #(.ACC_W(ACC_W)) cbus ();

   dpsk_correlator #(.SAMPLE_W(SAMPLE_W), .ACC_W(ACC_W)) u_corr (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .sample_i(sample_i),
      .sample_valid_i(sample_valid_i),
      .corr(cbus.src)
   );

   dpsk_pkg::rx_state_t state_reg;
   dpsk_pkg::rx_state_t state_next;
   logic [7:0] neg_cnt_reg;
   logic prev_neg_reg;
   logic [4:0] samp_cnt_reg;
   logic [4:0] target_reg;
   logic [10:0] hist_reg;
   logic [3:0] bit_cnt_reg;
   logic [6:0] hunt_cnt_reg;
   logic end_seen_reg;
   logic [7:0] byte_reg;
   logic byte_valid_reg;
   logic done_reg;
   logic error_reg;
   logic receiving_reg;

   // decode and selection
   wire logic corr_neg = cbus.value < 0;
   wire logic cv = cbus.valid;
   wire logic carrier_hit = neg_cnt_reg >= carrier_threshold_i;
   wire logic rise = cv && !corr_neg && prev_neg_reg;
   wire logic decide = cv && (state_reg == dpsk_pkg::ST_HUNT || state_reg == dpsk_pkg::ST_DATA)
                       && samp_cnt_reg == target_reg - 5'h01;
   wire logic [10:0] word = {hist_reg[9:0], corr_neg};
   wire logic sync_hit = word == dpsk_pkg::SYNC_WORD;
   wire logic end_hit = word == dpsk_pkg::END_WORD;
   wire logic [7:0] data_bits = word[dpsk_pkg::DATA_MSB:dpsk_pkg::DATA_LSB];
   wire logic parity_ok = word[dpsk_pkg::PARITY_POS] == ^data_bits;
   wire logic suffix_ok = word[1:0] == dpsk_pkg::SUFFIX;
   wire logic word_end = decide && state_reg == dpsk_pkg::ST_DATA
                         && bit_cnt_reg == 4'(dpsk_pkg::WORD_BITS - 1);
   wire logic word_good = word_end && !end_hit && !end_seen_reg && parity_ok && suffix_ok;
   wire logic word_bad = word_end && !end_hit && !(word_good);
   wire logic pkt_close = word_end && end_hit && end_seen_reg;
   wire logic hunt_out = decide && state_reg == dpsk_pkg::ST_HUNT && !sync_hit
                         && hunt_cnt_reg == 7'(HUNT_LIMIT - 1);

   // carrier search, then window alignment, then sync hunt, then words
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dpsk_pkg::ST_SEARCH: begin
            if (cv && corr_neg && carrier_hit) begin
               state_next = dpsk_pkg::ST_ALIGN;
            end
         end
         dpsk_pkg::ST_ALIGN: begin
            if (rise) begin
               state_next = dpsk_pkg::ST_HUNT;
            end
         end
         dpsk_pkg::ST_HUNT: begin
            if (decide && sync_hit) begin
               state_next = dpsk_pkg::ST_DATA;
            end else if (hunt_out) begin
               state_next = dpsk_pkg::ST_SEARCH;
            end
         end
         dpsk_pkg::ST_DATA: begin
            if (word_bad || pkt_close) begin
               state_next = dpsk_pkg::ST_SEARCH;
            end
         end
         default: begin
            state_next = dpsk_pkg::ST_SEARCH;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg <= dpsk_pkg::ST_SEARCH;
         neg_cnt_reg <= 8'h00;
         prev_neg_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (cv) begin
            prev_neg_reg <= corr_neg;
         end
         if (state_reg != dpsk_pkg::ST_SEARCH) begin
            neg_cnt_reg <= 8'h00;
         end else if (cv && !corr_neg) begin
            neg_cnt_reg <= 8'h00;
         end else if (cv && neg_cnt_reg != 8'hFF) begin
            neg_cnt_reg <= neg_cnt_reg + 8'h01;
         end
      end
   end

   // bit window timing
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         samp_cnt_reg <= 5'h00;
         target_reg <= 5'(dpsk_pkg::CENTRE_OFFSET);
      end else if (state_reg == dpsk_pkg::ST_ALIGN && rise) begin
         samp_cnt_reg <= 5'h00;
         target_reg <= 5'(dpsk_pkg::CENTRE_OFFSET);
      end else if (decide) begin
         samp_cnt_reg <= 5'h00;
         target_reg <= 5'(dpsk_pkg::BIT_SAMPLES);
      end else if (cv) begin
         samp_cnt_reg <= samp_cnt_reg + 5'h01;
      end
   end

   // bit history and word framing
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         hist_reg <= 11'h000;
         bit_cnt_reg <= 4'h0;
         hunt_cnt_reg <= 7'h00;
         end_seen_reg <= 1'b0;
      end else begin
         if (state_reg == dpsk_pkg::ST_ALIGN) begin
            hist_reg <= 11'h000;
            hunt_cnt_reg <= 7'h00;
            end_seen_reg <= 1'b0;
         end else if (decide) begin
            hist_reg <= word;
            hunt_cnt_reg <= hunt_cnt_reg + 7'h01;
         end
         if (state_reg != dpsk_pkg::ST_DATA || word_end) begin
            bit_cnt_reg <= 4'h0;
         end else if (decide) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         if (word_end && end_hit) begin
            end_seen_reg <= 1'b1;
         end
      end
   end

   // outputs to the medium access logic
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         byte_reg <= 8'h00;
         byte_valid_reg <= 1'b0;
         done_reg <= 1'b0;
         error_reg <= 1'b0;
         receiving_reg <= 1'b0;
      end else begin
         byte_valid_reg <= word_good;
         if (word_good) begin
            byte_reg <= data_bits;
         end
         done_reg <= pkt_close;
         error_reg <= word_bad;
         receiving_reg <= state_next != dpsk_pkg::ST_SEARCH;
      end
   end

   assign byte_o = byte_reg;
   assign byte_valid_o = byte_valid_reg;
   assign packet_done_o = done_reg;
   assign error_o = error_reg;
   assign receiving_o = receiving_reg;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_carrier;
      state_reg == dpsk_pkg::ST_SEARCH && cv && corr_neg && carrier_hit;
   endsequence
   sequence s_aligned;
      state_reg == dpsk_pkg::ST_ALIGN && rise;
   endsequence

   carrier_declare_a: assert property (s_carrier |=> state_reg == dpsk_pkg::ST_ALIGN)
      else $error("carrier not declared at threshold");
   carrier_clear_a: assert property (state_reg == dpsk_pkg::ST_SEARCH && cv && !corr_neg
      |=> neg_cnt_reg == 8'h00)
      else $error("carrier count not cleared");
   window_centre_a: assert property (s_aligned ##1 (!cv) [*1] ##0 1'b1
      |-> samp_cnt_reg == 5'h00 && target_reg == 5'(dpsk_pkg::CENTRE_OFFSET))
      else $error("window centre not set");
   bit_interval_a: assert property (decide && state_reg == dpsk_pkg::ST_DATA
      |=> target_reg == 5'(dpsk_pkg::BIT_SAMPLES) && samp_cnt_reg == 5'h00)
      else $error("bit interval wrong");
   bit_decode_a: assert property (decide |=> hist_reg[0] == $past(corr_neg))
      else $error("bit decode wrong");
   sync_found_a: assert property (state_reg == dpsk_pkg::ST_HUNT && decide && sync_hit
      |=> state_reg == dpsk_pkg::ST_DATA && bit_cnt_reg == 4'h0)
      else $error("sync word not taken");
   byte_strip_a: assert property (word_good |=> byte_valid_o && byte_o == $past(word[10:3]))
      else $error("byte not stripped");
   parity_check_a: assert property (byte_valid_o |-> $past(word[2]) == ^byte_o && $past(word[1:0]) == 2'h1)
      else $error("byte passed with bad parity or suffix");
   error_abort_a: assert property (word_bad |=> error_o && state_reg == dpsk_pkg::ST_SEARCH)
      else $error("error did not abort packet");
   packet_end_a: assert property (packet_done_o |-> state_reg == dpsk_pkg::ST_SEARCH && !receiving_o)
      else $error("packet not closed");
   order_a: assert property (state_reg == dpsk_pkg::ST_DATA
      |-> $past(state_reg) inside {dpsk_pkg::ST_HUNT, dpsk_pkg::ST_DATA})
      else $error("data state entered out of order");
endmodule : dpsk_packet_detector

// ---- hw/dpsk_pkg.sv ----
// constants, types and field layout for the differential phase packet detector
package dpsk_pkg;
   localparam int SAMPLE_RATE_HZ = 137000;
   localparam int BIT_SAMPLES = 25;
   localparam int CENTRE_OFFSET = 12;
   localparam int WORD_BITS = 11;
   localparam logic [10:0] SYNC_WORD = 11'h67B;
   localparam logic [10:0] END_WORD = 11'h733;
   localparam int DATA_MSB = 10;
   localparam int DATA_LSB = 3;
   localparam int PARITY_POS = 2;
   localparam logic [1:0] SUFFIX = 2'h1;
   localparam int END_WORDS = 2;
   localparam logic [7:0] THRESHOLD_RESET = 8'h00;
   typedef enum logic [2:0] {
      ST_SEARCH = 3'b000,
      ST_ALIGN = 3'b001,
      ST_HUNT = 3'b010,
      ST_DATA = 3'b011
   } rx_state_t;
endpackage : dpsk_pkg

// ---- hw/corr_if.sv ----
// correlator result carrier between correlator and detector
`timescale 1ns/10ps
interface corr_if #(parameter int ACC_W = 37);
   logic valid;
   logic signed [ACC_W-1:0] value;
   modport src (output valid, output value);
   modport dst (input valid, input value);
endinterface : corr_if

// ---- hw/dpsk_correlator.sv ----
// sliding correlation of each 25-sample bit field against the one before it
`timescale 1ns/10ps
module dpsk_correlator #(
   parameter int SAMPLE_W = 16,
   parameter int ACC_W = 37
) (
   input wire logic sys_clk_i,                    // system clock
   input wire logic rst_i,                        // synchronous reset
   input wire logic signed [SAMPLE_W-1:0] sample_i, // filtered sample
   input wire logic sample_valid_i,               // one strobe per sample
   corr_if.src corr                               // correlation result
);
   localparam int DEPTH = 2 * dpsk_pkg::BIT_SAMPLES;
   localparam int PW = 2 * SAMPLE_W;

   logic signed [SAMPLE_W-1:0] hist_reg [0:DEPTH-1];
   logic signed [ACC_W-1:0] acc_reg;
   logic valid_reg;
   wire logic signed [PW-1:0] prod_new;
   wire logic signed [PW-1:0] prod_old;
   wire logic signed [ACC_W-1:0] acc_next;

   // newest product enters, the one 25 samples older leaves the window
   assign prod_new = sample_i * hist_reg[dpsk_pkg::BIT_SAMPLES-1];
   assign prod_old = hist_reg[dpsk_pkg::BIT_SAMPLES-1] * hist_reg[DEPTH-1];
   assign acc_next = acc_reg + ACC_W'(prod_new) - ACC_W'(prod_old);

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_tap
         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               hist_reg[g] <= '0;
            end else if (sample_valid_i) begin
               hist_reg[g] <= (g == 0) ? sample_i : hist_reg[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         acc_reg <= '0;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= sample_valid_i;
         if (sample_valid_i) begin
            acc_reg <= acc_next;
         end
      end
   end

   assign corr.valid = valid_reg;
   assign corr.value = acc_reg;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   corr_follows_a: assert property (sample_valid_i |=> valid_reg && acc_reg == $past(acc_next))
      else $error("correlation not updated after sample");
   corr_holds_a: assert property (!sample_valid_i |=> !valid_reg && $stable(acc_reg))
      else $error("correlation changed without sample");
endmodule : dpsk_correlator

// ---- test/dpsk_line_model.sv ----
// behavioural far-end transmitter, one constant-phase level per bit field
`timescale 1ns/10ps
module dpsk_line_model #(
   parameter int SAMPLE_W = 16,
   parameter int AMP = 1000
) (
   input wire logic sys_clk_i,                  // system clock
   output logic signed [SAMPLE_W-1:0] sample_o, // line sample
   output logic sample_valid_o                  // sample strobe
);
   logic phase_reg;
   initial begin
      sample_o = '0;
      sample_valid_o = 1'b0;
      phase_reg = 1'b0;
   end
   // one bit field; level zero when the line is idle, strobe every other cycle
   task automatic field(input logic level_on);
      repeat (dpsk_pkg::BIT_SAMPLES) begin
         @(posedge sys_clk_i);
         sample_valid_o <= 1'b1;
         sample_o <= !level_on ? '0 : (phase_reg ? SAMPLE_W'(-AMP) : SAMPLE_W'(AMP));
         @(posedge sys_clk_i);
         sample_valid_o <= 1'b0;
      end
   endtask : field
   // running exclusive-or so the far end's phase difference gives the bit back
   task automatic send_bit(input logic b);
      phase_reg = phase_reg ^ b;
      field(1'b1);
   endtask : send_bit
   // msb first; each word stands alone since every bit is a phase difference, not all words end in a one
   task automatic send_word(input logic [10:0] w);
      for (int i = 10; i >= 0; i--) begin
         send_bit(w[i]);
      end
   endtask : send_word
   task automatic idle(input int n);
      repeat (n) field(1'b0);
   endtask : idle
endmodule : dpsk_line_model

// ---- test/dpsk_packet_detector_test.sv ----
// self-checking bench for the packet detector driven by the line model
`timescale 1ns/10ps
module dpsk_packet_detector_test;
   logic sys_clk_i;
   logic rst_i;
   logic [7:0] carrier_threshold_i;
   logic signed [15:0] sample_i;
   logic sample_valid_i;
   logic [7:0] byte_o;
   logic byte_valid_o;
   logic packet_done_o;
   logic error_o;
   logic receiving_o;
   int mismatches;
   int checks;
   int done_cnt;
   int err_cnt;
   logic seen_rx;
   logic [7:0] got_q[$];

   dpsk_line_model #(.SAMPLE_W(16), .AMP(1003)) dpsk_line_model_inst (
      .sys_clk_i(sys_clk_i),
      .sample_o(sample_i),
      .sample_valid_o(sample_valid_i)
   );
   dpsk_packet_detector #(.SAMPLE_W(16), .HUNT_LIMIT(20)) dpsk_packet_detector_inst (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .sample_i(sample_i),
      .sample_valid_i(sample_valid_i),
      .carrier_threshold_i(carrier_threshold_i),
      .byte_o(byte_o),
      .byte_valid_o(byte_valid_o),
      .packet_done_o(packet_done_o),
      .error_o(error_o),
      .receiving_o(receiving_o)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   // strobes last one cycle, so they are collected at the following edge
   always @(posedge sys_clk_i) begin
      if (rst_i === 1'b0) begin
         if (byte_valid_o === 1'b1) got_q.push_back(byte_o);
         if (packet_done_o === 1'b1) done_cnt++;
         if (error_o === 1'b1) err_cnt++;
         if (receiving_o === 1'b1) seen_rx = 1'b1;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   function automatic logic [10:0] make_word(input logic [7:0] d, input logic flip, input logic [1:0] sfx);
      return {d, ^d ^ flip, sfx};
   endfunction : make_word

   task automatic start_packet(input int pre_bits);
      got_q.delete();
      done_cnt = 0;
      err_cnt = 0;
      seen_rx = 1'b0;
      for (int i = 0; i < pre_bits; i++) dpsk_line_model_inst.send_bit(1'b1);
      // two same-phase fields give the negative-to-positive turn
      dpsk_line_model_inst.send_bit(1'b0);
      dpsk_line_model_inst.send_bit(1'b0);
      dpsk_line_model_inst.send_word(dpsk_pkg::SYNC_WORD);
   endtask : start_packet

   task automatic bad_word_packet(input logic flip, input logic [1:0] sfx);
      start_packet(24);
      dpsk_line_model_inst.send_word(make_word(8'h5A, 1'b0, dpsk_pkg::SUFFIX));
      dpsk_line_model_inst.send_word(make_word(8'hC3, flip, sfx));
      dpsk_line_model_inst.idle(3);
      check("bad word bytes", got_q.size(), 1);
      if (got_q.size() > 0) check("bad word first byte", got_q[0], 8'h5A);
      check("bad word error", err_cnt, 1);
      check("bad word done", done_cnt, 0);
      check("bad word receiving", receiving_o, 1'b0);
   endtask : bad_word_packet

   // two runs of negatives, each under the threshold, split by one positive field
   task automatic split_preamble();
      for (int i = 0; i < 6; i++) dpsk_line_model_inst.send_bit(1'b1);
      dpsk_line_model_inst.send_bit(1'b0);
      start_packet(6);
      dpsk_line_model_inst.send_word(make_word(8'h00, 1'b0, dpsk_pkg::SUFFIX));
      dpsk_line_model_inst.idle(3);
      check("split preamble receiving", seen_rx, 1'b0);
      check("split preamble bytes", got_q.size(), 0);
   endtask : split_preamble

   // carrier and window found but no sync word follows: hunt gives up
   task automatic lost_sync();
      got_q.delete();
      seen_rx = 1'b0;
      for (int i = 0; i < 24; i++) dpsk_line_model_inst.send_bit(1'b1);
      dpsk_line_model_inst.idle(22);
      check("lost sync receiving seen", seen_rx, 1'b1);
      check("lost sync bytes", got_q.size(), 0);
      check("lost sync receiving after", receiving_o, 1'b0);
   endtask : lost_sync

   task automatic good_packet();
      logic [7:0] data [4] = '{8'hA5, 8'h00, 8'hFF, 8'h3C};
      carrier_threshold_i <= 8'h37;
      start_packet(24);
      foreach (data[i]) dpsk_line_model_inst.send_word(make_word(data[i], 1'b0, dpsk_pkg::SUFFIX));
      dpsk_line_model_inst.send_word(dpsk_pkg::END_WORD);
      dpsk_line_model_inst.send_word(dpsk_pkg::END_WORD);
      dpsk_line_model_inst.idle(3);
      check("good receiving seen", seen_rx, 1'b1);
      check("good byte count", got_q.size(), 4);
      foreach (data[i]) begin
         if (i < got_q.size()) check("good byte", got_q[i], data[i]);
      end
      check("good done", done_cnt, 1);
      check("good error", err_cnt, 0);
      check("good receiving after", receiving_o, 1'b0);
   endtask : good_packet

   task automatic finish_test();
      if (mismatches == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      rst_i = 1'b1;
      carrier_threshold_i = 8'hC8;
      mismatches = 0;
      checks = 0;
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      dpsk_line_model_inst.idle(2);
      bad_word_packet(1'b1, dpsk_pkg::SUFFIX);
      bad_word_packet(1'b0, 2'h0);
      split_preamble();
      lost_sync();
      good_packet();
      finish_test();
   end
endmodule : dpsk_packet_detector_test
